// >>> include/cbp_pkg.sv
// Purpose: Shared constants and carriers for the coax and buffer parity block
// Assumes: 40 MHz system clock, AXI4-Lite register access
// Notes:   Register offsets are byte addresses of aligned 32-bit words
package cbp_pkg;
   localparam logic [3:0]  SER_BITS       = 4'hc;
   localparam logic [3:0]  PAR_BIT_NUM    = 4'hc;
   localparam logic [10:0] LAST_CHECK_ADDR = 11'h77f;
   localparam logic [7:0]  NULL_CODE      = 8'h00;
   localparam int          CMD_DEVCHK_BIT = 4;
   localparam logic [7:0]  CMD_RESET      = 8'h00;
   localparam logic [3:0]  OFF_CMD        = 4'h0;
   localparam logic [3:0]  OFF_STATUS     = 4'h4;
   localparam logic [3:0]  OFF_CTRL       = 4'h8;
   localparam int          ST_XMIT_CHK    = 0;
   localparam int          ST_BUF_FAULT   = 1;
   localparam int          ST_INIT_HOLD   = 2;
   localparam int          ST_CLEARED     = 3;
   localparam int          CT_INIT_DONE   = 0;
   localparam int          CT_BUF_CLEARED = 1;
   localparam int          CT_CLR_CMD     = 2;

   typedef struct packed {
      logic [7:0] data;
      logic       cursor;
      logic       parity;
   } cbp_buf_word_t;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_SHIFT = 2'b01,
      TX_PAR   = 2'b11,
      TX_LAST  = 2'b10
   } cbp_tx_state_t;
endpackage

// >>> verilog/cbp_parity.sv
// Purpose: Serial coax parity and parallel display buffer parity
// Assumes: Bit strobes and buffer phase-4 clock are sync pulses on sys_clk_i
// Notes:   Coax serial input arrives from a pin and is synchronised
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Receive parity held set while the shift register is empty
// - Receive parity toggles per received one; set after bit twelve means good
// - Control characters with bad parity are not decoded
// - Data characters with bad parity are stored as null
// - Any bad received character sets the transmit-check latch
// - Transmit parity cleared on load, toggles per one shifted out
// - Bit twelve on the line is the inverse of the transmit parity value
// - First and thirteenth bits on the line are ones
// - Parity bit makes bits one to twelve odd; bit thirteen excluded
// - Buffer write parity is odd over eight data bits, cursor excluded
// - Buffer read check sampled on trailing edge of phase four
// - Buffer fault latch set sets the device-check latch
// - Read cursor bit excluded from read parity check
// - No read check during buffer writes
// - No read check after power-on until buffer cleared
// - No read check above address 1919
// - Two twelve-bit shift registers, one for receive and one for transmit
// - Initialize hold blocks coax traffic and buffer checking
// - Device-check is command bit 4; any command bit raises NMI
// - Reset-transmit-check or write command clears transmit-check latch
module cbp_parity
   import cbp_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        clk_en_i,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Coax serial side
   input  wire logic        coax_rx_i,
   input  wire logic        rx_bit_strobe_i,
   input  wire logic        rx_is_control_i,
   output logic             rx_char_valid_o,
   output logic [7:0]       rx_data_o,
   output logic             rx_ctrl_decode_o,
   input  wire logic        tx_load_i,
   input  wire logic [10:0] tx_char_i,
   input  wire logic        tx_bit_strobe_i,
   output logic             coax_tx_o,
   output logic             tx_busy_o,
   input  wire logic        rst_xmit_check_cmd_i,
   input  wire logic        write_cmd_i,
   // Display buffer side
   input  wire logic        buf_write_i,
   input  wire logic [7:0]  buf_wdata_i,
   input  wire logic        write_cursor_bit_i,
   output logic [9:0]       buf_wword_o,
   input  wire logic        buf_ph4_i,
   input  wire logic [10:0] buf_addr_i,
   input  wire logic [7:0]  buf_rdata_i,
   input  wire logic        read_cursor_bit_i,
   input  wire logic        buf_rparity_i,
   input  wire logic [7:0]  cmd_other_i,
   output logic             nmi_o,
   output logic             init_hold_o
);

   function automatic logic odd_par(input logic [7:0] d);
      odd_par = ~(^d);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Receive path
   logic        rx_s1_q, rx_s2_q;
   logic [11:0] rx_sr_q;
   logic [3:0]  rx_cnt_q;
   logic        rx_par_q;
   logic        rx_done_q;
   logic        xmit_check_q;
   logic        init_hold_q;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         rx_s1_q <= coax_rx_i;
         rx_s2_q <= rx_s1_q;
      end
   end

   // Shift register, counter, parity; empty after each character
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_sr_q   <= 12'h000;
         rx_cnt_q  <= 4'h0;
         rx_par_q  <= 1'b1;
         rx_done_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         rx_done_q <= 1'b0;
         if (init_hold_q || rx_cnt_q == 4'h0 && !rx_bit_strobe_i)
            rx_par_q <= 1'b1;
         if (!init_hold_q && rx_bit_strobe_i)
         begin
            rx_sr_q <= {rx_sr_q[10:0], rx_s2_q};
            if (rx_s2_q)
               rx_par_q <= (rx_cnt_q == 4'h0) ? 1'b0 : ~rx_par_q;
            if (rx_cnt_q == SER_BITS - 4'h1)
            begin
               rx_cnt_q  <= 4'h0;
               rx_done_q <= 1'b1;
            end
            else
               rx_cnt_q <= rx_cnt_q + 4'h1;
         end
      end
   end

   logic rx_good;
   assign rx_good = rx_par_q;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_char_valid_o  <= 1'b0;
         rx_data_o        <= 8'h00;
         rx_ctrl_decode_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         rx_char_valid_o  <= rx_done_q && !rx_is_control_i;
         rx_ctrl_decode_o <= rx_done_q && rx_is_control_i && rx_good;
         if (rx_done_q)
            rx_data_o <= rx_good ? rx_sr_q[8:1] : NULL_CODE;
      end
   end

   // Set wins over a same-cycle clear
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         xmit_check_q <= 1'b0;
      else if (clk_en_i)
      begin
         if (rx_done_q && !rx_good)
            xmit_check_q <= 1'b1;
         else if (rst_xmit_check_cmd_i || write_cmd_i)
            xmit_check_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit path: bit1 one, bits 2..11 data, bit12 parity, bit13 one
   cbp_tx_state_t tx_st_q;
   logic [11:0]   tx_sr_q;
   logic [3:0]    tx_cnt_q;
   logic          tx_par_q;
   logic          tx_bit;

   assign tx_bit = tx_sr_q[11];

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         tx_st_q   <= TX_IDLE;
         tx_sr_q   <= 12'h000;
         tx_cnt_q  <= 4'h0;
         tx_par_q  <= 1'b0;
         coax_tx_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         case (tx_st_q)
            TX_IDLE:
            begin
               if (tx_load_i && !init_hold_q)
               begin
                  // First and twelfth stages forced to one; caller's top bit is ignored
                  tx_sr_q  <= {1'b1, tx_char_i[9:0], 1'b1};
                  tx_par_q <= 1'b0;
                  tx_cnt_q <= 4'h1;
                  tx_st_q  <= TX_SHIFT;
               end
            end
            TX_SHIFT:
            begin
               if (tx_bit_strobe_i)
               begin
                  coax_tx_o <= tx_bit;
                  tx_par_q  <= tx_par_q ^ tx_bit;
                  tx_sr_q   <= {tx_sr_q[10:0], 1'b0};
                  tx_cnt_q  <= tx_cnt_q + 4'h1;
                  if (tx_cnt_q == PAR_BIT_NUM - 4'h1)
                     tx_st_q <= TX_PAR;
               end
            end
            TX_PAR:
            begin
               if (tx_bit_strobe_i)
               begin
                  coax_tx_o <= ~tx_par_q;
                  tx_st_q   <= TX_LAST;
               end
            end
            TX_LAST:
            begin
               if (tx_bit_strobe_i)
               begin
                  coax_tx_o <= 1'b1;
                  tx_st_q   <= TX_IDLE;
               end
            end
            default:
               tx_st_q <= TX_IDLE;
         endcase
      end
   end

   assign tx_busy_o = (tx_st_q != TX_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Buffer parity
   logic ph4_d1_q;
   logic buf_fault_q;
   logic buf_cleared_q;
   logic clr_cmd_q;
   logic chk_en;
   logic ph4_fall;
   logic rd_bad;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         buf_wword_o <= 10'h000;
      else if (clk_en_i && buf_write_i)
         buf_wword_o <= {buf_wdata_i, write_cursor_bit_i,
                         odd_par(buf_wdata_i)};
   end

   assign ph4_fall = ph4_d1_q && !buf_ph4_i;
   assign rd_bad   = odd_par(buf_rdata_i) != buf_rparity_i;
   assign chk_en   = !init_hold_q && buf_cleared_q
                     && !buf_write_i
                     && buf_addr_i <= LAST_CHECK_ADDR;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         ph4_d1_q    <= 1'b0;
         buf_fault_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         ph4_d1_q <= buf_ph4_i;
         if (ph4_fall && chk_en && rd_bad)
            buf_fault_q <= 1'b1;
         else if (clr_cmd_q)
            buf_fault_q <= 1'b0;
      end
   end

   logic dev_check_q;
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         dev_check_q <= 1'b0;
      else if (clk_en_i)
      begin
         // A pending clear drops the old fault first; a fresh fault re-sets it next cycle
         if (buf_fault_q && !clr_cmd_q)
            dev_check_q <= 1'b1;
         else if (clr_cmd_q)
            dev_check_q <= 1'b0;
      end
   end

   logic [7:0] cmd_flags;
   always_comb
   begin
      cmd_flags = cmd_other_i;
      cmd_flags[CMD_DEVCHK_BIT] = dev_check_q;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         nmi_o <= 1'b0;
      else if (clk_en_i)
         nmi_o <= |cmd_flags;
   end

   assign init_hold_o = init_hold_q;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: write waits for both channels, reads answer next cycle
   logic aw_hold_q, w_hold_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wr_go;

   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = (aw_hold_q || s_axi_awvalid) && (w_hold_q || s_axi_wvalid)
                  && !s_axi_bvalid;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         awaddr_q      <= 4'h0;
         wdata_q       <= 32'h0000_0000;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         init_hold_q   <= 1'b1;
         buf_cleared_q <= 1'b0;
         clr_cmd_q     <= 1'b0;
      end
      else if (clk_en_i)
      begin
         clr_cmd_q <= 1'b0;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
         end
         if (wr_go)
         begin
            automatic logic [3:0]  a = aw_hold_q ? awaddr_q : s_axi_awaddr;
            automatic logic [31:0] d = w_hold_q ? wdata_q : s_axi_wdata;
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            if (a == OFF_CTRL && s_axi_wstrb[0])
            begin
               if (d[CT_INIT_DONE])
                  init_hold_q <= 1'b0;
               if (d[CT_BUF_CLEARED])
                  buf_cleared_q <= 1'b1;
               clr_cmd_q <= d[CT_CLR_CMD];
            end
            else if (a != OFF_CTRL)
               s_axi_bresp <= 2'b10;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end
      else if (clk_en_i)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
               OFF_CMD:    s_axi_rdata <= {24'h000000, cmd_flags};
               OFF_STATUS: s_axi_rdata <= {28'h0000000, buf_cleared_q, init_hold_q,
                                           buf_fault_q, xmit_check_q};
               OFF_CTRL:   s_axi_rdata <= {30'h0, buf_cleared_q, !init_hold_q};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_fault_sets_devchk;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && buf_fault_q && !clr_cmd_q |=> dev_check_q;
   endproperty
   a_fault_sets_devchk: assert property (p_fault_sets_devchk)
      else $error("Device check not set after buffer fault");

   property p_no_check_in_write;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && buf_write_i && !buf_fault_q && !clr_cmd_q |=> !buf_fault_q;
   endproperty
   a_no_check_in_write: assert property (p_no_check_in_write)
      else $error("Buffer fault set during a write");

   property p_no_check_high;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && buf_addr_i > LAST_CHECK_ADDR && !buf_fault_q |=> !buf_fault_q;
   endproperty
   a_no_check_high: assert property (p_no_check_high)
      else $error("Buffer fault set above last checked address");

   property p_hold_blocks;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      init_hold_q |-> !buf_fault_q && tx_st_q == TX_IDLE;
   endproperty
   a_hold_blocks: assert property (p_hold_blocks)
      else $error("Activity during initialize hold");

   property p_bad_null;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && rx_done_q && !rx_good |=> rx_data_o == NULL_CODE && !rx_ctrl_decode_o;
   endproperty
   a_bad_null: assert property (p_bad_null)
      else $error("Bad character not nulled");

   property p_xchk;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && rx_done_q && !rx_good |=> xmit_check_q;
   endproperty
   a_xchk: assert property (p_xchk)
      else $error("Transmit check not set");

   property p_nmi;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && dev_check_q |=> nmi_o;
   endproperty
   a_nmi: assert property (p_nmi)
      else $error("No interrupt with device check");

   property p_rx_empty_set;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i && rx_cnt_q == 4'h0 && !rx_bit_strobe_i |=> rx_par_q;
   endproperty
   a_rx_empty_set: assert property (p_rx_empty_set)
      else $error("Receive parity not held set while empty");

   c_tx: cover property (@(posedge sys_clk_i) tx_st_q == TX_LAST);
   c_fault: cover property (@(posedge sys_clk_i) buf_fault_q);
   c_rxbad: cover property (@(posedge sys_clk_i) rx_done_q && !rx_good);
endmodule // cbp_parity

`default_nettype wire

// >>> verification/cbp_host_model.sv
// Purpose: Host controller model on the far side of the coax serial link
// Assumes: One bit per strobe; the receive line is synchronised inside the block
// Notes:   Between frames the line shows the inverse of the last bit sent
`timescale 1ns/1ps
`default_nettype none

module cbp_host_model (
   input  wire logic sys_clk_i,
   input  wire logic coax_tx_i,
   output logic      coax_rx_o,
   output logic      rx_strobe_o,
   output logic      tx_strobe_o
);
   initial
   begin
      coax_rx_o   = 1'b0;
      rx_strobe_o = 1'b0;
      tx_strobe_o = 1'b0;
   end

   // Three cycles of settle time cover the two-stage synchroniser
   task automatic send_char(input logic [11:0] c);
      for (int i = 11; i >= 0; i--)
      begin
         coax_rx_o <= c[i];
         repeat (3) @(posedge sys_clk_i);
         rx_strobe_o <= 1'b1;
         @(posedge sys_clk_i);
         rx_strobe_o <= 1'b0;
      end
      coax_rx_o <= ~c[0];
   endtask

   task automatic recv_char(output logic [12:0] b);
      for (int i = 12; i >= 0; i--)
      begin
         tx_strobe_o <= 1'b1;
         @(posedge sys_clk_i);
         tx_strobe_o <= 1'b0;
         repeat (2) @(negedge sys_clk_i);
         b[i] = coax_tx_i;
         @(posedge sys_clk_i);
      end
   endtask
endmodule // cbp_host_model

`default_nettype wire

// >>> verification/coax_buffer_parity_tb.sv
// Purpose: Self-checking bench for the coax and buffer parity block
// Assumes: Register map and timings as handed over with the design
// Notes:   Bus tasks sample ready and valid at the falling edge before the rising one
`timescale 1ns/1ps
`default_nettype none

module coax_buffer_parity_tb
   import cbp_pkg::*;
;
   logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        coax_rx_i, rx_bit_strobe_i, tx_bit_strobe_i, coax_tx_o, tx_busy_o;
   logic        rx_is_control_i = 1'b0, tx_load_i = 1'b0, rst_xmit_check_cmd_i = 1'b0;
   logic        write_cmd_i = 1'b0, buf_write_i = 1'b0, write_cursor_bit_i = 1'b0;
   logic        buf_ph4_i = 1'b0, read_cursor_bit_i = 1'b0, buf_rparity_i = 1'b0;
   logic [10:0] tx_char_i = 11'h0, buf_addr_i = 11'h0;
   logic [7:0]  buf_wdata_i = 8'h00, buf_rdata_i = 8'h00, cmd_other_i = 8'h00;
   logic        rx_char_valid_o, rx_ctrl_decode_o, nmi_o, init_hold_o;
   logic [7:0]  rx_data_o;
   logic [9:0]  buf_wword_o;
   int          n_mismatch = 0, samples_checked = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   cbp_parity i_cbp_parity (.sys_clk_i, .rst_n_i, .clk_en_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .coax_rx_i, .rx_bit_strobe_i,
      .rx_is_control_i, .rx_char_valid_o, .rx_data_o, .rx_ctrl_decode_o, .tx_load_i,
      .tx_char_i, .tx_bit_strobe_i, .coax_tx_o, .tx_busy_o, .rst_xmit_check_cmd_i,
      .write_cmd_i, .buf_write_i, .buf_wdata_i, .write_cursor_bit_i, .buf_wword_o,
      .buf_ph4_i, .buf_addr_i, .buf_rdata_i, .read_cursor_bit_i, .buf_rparity_i,
      .cmd_other_i, .nmi_o, .init_hold_o);

   cbp_host_model i_cbp_host_model (.sys_clk_i, .coax_tx_i(coax_tx_o), .coax_rx_o(coax_rx_i),
      .rx_strobe_o(rx_bit_strobe_i), .tx_strobe_o(tx_bit_strobe_i));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic nmi_is(input logic e);
      @(negedge sys_clk_i);
      chk(nmi_o, e);
      @(posedge sys_clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb, done;
      logic [1:0] r;
      int n;
      done = 1'b0;
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!done)
      begin
         @(negedge sys_clk_i);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bready && s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge sys_clk_i);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
         done = tb;
         n++;
         if (n > 50)
         begin
            n_mismatch++;
            print_verdict();
         end
      end
      tick(1);
      chk(r, er);
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, done;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      done = 1'b0;
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!done)
      begin
         @(negedge sys_clk_i);
         ta = s_axi_arvalid && s_axi_arready;
         done = s_axi_rready && s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge sys_clk_i);
         if (ta) s_axi_arvalid <= 1'b0;
         if (done) s_axi_rready <= 1'b0;
         n++;
         if (n > 50)
         begin
            n_mismatch++;
            print_verdict();
         end
      end
      tick(1);
      chk(d, ed);
      chk(r, er);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // One phase-4 cycle; good selects correct odd parity on the read side
   task automatic bufcyc(input logic [10:0] a, input logic [7:0] d, input logic c,
                         input logic good, input logic wr);
      buf_addr_i         <= a;
      buf_rdata_i        <= d;
      buf_wdata_i        <= d;
      read_cursor_bit_i  <= c;
      write_cursor_bit_i <= c;
      buf_rparity_i      <= good ? ~^d : ^d;
      buf_write_i        <= wr;
      buf_ph4_i          <= 1'b1;
      tick(2);
      buf_ph4_i          <= 1'b0;
      tick(5);
      buf_write_i        <= 1'b0;
      tick(1);
      if (wr)
         chk(buf_wword_o, {d, c, ~^d});
   endtask

   task automatic rx(input logic [11:0] c, input logic ctl, input logic ev,
                     input logic [7:0] ed, input logic edc);
      logic v, dc;
      logic [7:0] d;
      v = 1'b0;
      dc = 1'b0;
      d = 8'h00;
      rx_is_control_i <= ctl;
      i_cbp_host_model.send_char(c);
      repeat (8)
      begin
         @(negedge sys_clk_i);
         if (rx_char_valid_o === 1'b1)
         begin
            v = 1'b1;
            d = rx_data_o;
         end
         if (rx_ctrl_decode_o === 1'b1) dc = 1'b1;
      end
      @(posedge sys_clk_i);
      chk(v, ev);
      if (ev)
         chk(d, ed);
      chk(dc, edc);
   endtask

   task automatic tx(input logic [10:0] c);
      logic [12:0] b;
      tx_char_i <= c;
      tx_load_i <= 1'b1;
      tick(1);
      tx_load_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(tx_busy_o, 1'b1);
      @(posedge sys_clk_i);
      i_cbp_host_model.recv_char(b);
      chk(b, {c, ~^c, 1'b1});
      @(negedge sys_clk_i);
      chk(tx_busy_o, 1'b0);
      @(posedge sys_clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(2);
      rst_n_i <= 1'b1;
      tick(1);
      axi_rd(OFF_CMD, 32'h0, 2'b00);
      axi_rd(OFF_STATUS, 32'h4, 2'b00);
      axi_rd(OFF_CTRL, 32'h0, 2'b00);
      axi_rd(4'hc, 32'h0, 2'b10);
      axi_wr(OFF_CMD, 32'h1, 2'b10);
      chk(init_hold_o, 1'b1);
      bufcyc(11'd5, 8'h3c, 1'b0, 1'b0, 1'b0);
      rx(12'h903, 1'b0, 1'b0, NULL_CODE, 1'b0);
      axi_rd(OFF_STATUS, 32'h4, 2'b00);
      axi_wr(OFF_CTRL, 32'h1, 2'b00);
      chk(init_hold_o, 1'b0);
      bufcyc(11'd5, 8'h3c, 1'b0, 1'b0, 1'b0);
      axi_rd(OFF_STATUS, 32'h0, 2'b00);
      axi_wr(OFF_CTRL, 32'h3, 2'b00);
      axi_rd(OFF_CTRL, 32'h3, 2'b00);
      // Writes carry bad read parity: a fault here means writes were not masked
      for (int i = 0; i < 4; i++)
         bufcyc(11'd7, 8'h7e ^ (8'h81 << i), i[0], 1'b0, 1'b1);
      bufcyc(11'd1920, 8'h3c, 1'b0, 1'b0, 1'b0);
      bufcyc(11'd1919, 8'h3d, 1'b1, 1'b1, 1'b0);
      axi_rd(OFF_STATUS, 32'h8, 2'b00);
      bufcyc(11'd1919, 8'h3c, 1'b0, 1'b0, 1'b0);
      nmi_is(1'b1);
      bufcyc(11'd0, 8'h3c, 1'b0, 1'b1, 1'b0);
      axi_rd(OFF_STATUS, 32'ha, 2'b00);
      axi_rd(OFF_CMD, 32'h10, 2'b00);
      axi_wr(OFF_CTRL, 32'h7, 2'b00);
      tick(3);
      nmi_is(1'b0);
      axi_rd(OFF_CMD, 32'h0, 2'b00);
      cmd_other_i <= 8'h10;
      tick(4);
      nmi_is(1'b0);
      cmd_other_i <= 8'h80;
      tick(4);
      nmi_is(1'b1);
      axi_rd(OFF_CMD, 32'h80, 2'b00);
      clk_en_i    <= 1'b0;
      cmd_other_i <= 8'h00;
      tick(4);
      nmi_is(1'b1);
      clk_en_i    <= 1'b1;
      tick(2);
      nmi_is(1'b0);
      rx(12'h903, 1'b0, 1'b1, 8'h81, 1'b0);
      axi_rd(OFF_STATUS, 32'h8, 2'b00);
      rx(12'h902, 1'b0, 1'b1, NULL_CODE, 1'b0);
      axi_rd(OFF_STATUS, 32'h9, 2'b00);
      rx(12'h903, 1'b0, 1'b1, 8'h81, 1'b0);
      rst_xmit_check_cmd_i <= 1'b1;
      tick(1);
      rst_xmit_check_cmd_i <= 1'b0;
      axi_rd(OFF_STATUS, 32'h8, 2'b00);
      rx(12'h902, 1'b1, 1'b0, NULL_CODE, 1'b0);
      axi_rd(OFF_STATUS, 32'h9, 2'b00);
      write_cmd_i <= 1'b1;
      tick(1);
      write_cmd_i <= 1'b0;
      axi_rd(OFF_STATUS, 32'h8, 2'b00);
      rx(12'h903, 1'b1, 1'b0, NULL_CODE, 1'b1);
      tx(11'h400);
      tx(11'h401);
      print_verdict();
   end
endmodule // coax_buffer_parity_tb

`default_nettype wire
